// [blockage_diag_defs.svh]
`ifndef BLOCKAGE_DIAG_DEFS_SVH
`define BLOCKAGE_DIAG_DEFS_SVH

// ***************************************************************
// Register indices (byte address is four times the index)
// ***************************************************************
`define IDX_DIAG_MODE_SELECT     12'h0812
`define IDX_ACQUISITION_PERIOD   12'h0813
`define IDX_ALERT_PRIORITY       12'h0814
`define IDX_DIAG_RESULT_FLAGS    12'h0815
`define IDX_HIGH_SIDE_ALERT      12'h0816
`define IDX_LOW_SIDE_ALERT       12'h0817
`define IDX_ALARM_LINK_MASK      12'h0818
`define IDX_COMP_SELECT          12'h0819
`define IDX_HIT_LIMIT            12'h081a
`define IDX_BLOCK_MODE           12'h081b
`define IDX_DIAG_STATUS          12'h081c
`define IDX_REF_CAPTURE_TIME     12'h081d
`define IDX_DP_RATIO             12'h081e

// ***************************************************************
// Reset values
// ***************************************************************
`define RST_ACQUISITION_PERIOD   16'h00b4
`define RST_ALERT_PRIORITY       8'h01
`define RST_ALARM_LINK_MASK      16'h08fc
`define RST_HIT_LIMIT            8'h03
`define PERIOD_MIN               16'h0014

// ***************************************************************
// Result flag word layout
// ***************************************************************
`define FLG_DETECT_LSB           2
`define FLG_DETECT_MSB           7
`define FLG_INVALID_LSB          8
`define FLG_INVALID_MSB          11
`define FLG_OUT_OF_RANGE         12
`define FLG_FLANGE_LOW           13
`define FLG_FLANGE_HIGH          14
`define MASK_UNCERTAIN_LINK      15
`define HIGH_SIDE_SOURCES        16'h1bd4
`define LOW_SIDE_SOURCES         16'h1dac

// ***************************************************************
// Timing
// ***************************************************************
`define CLK_FREQ_HZ              40000000
`define SECOND_TICK_S            1
`define REF_SAMPLE_S             180

`endif

// [blockage_diag_param_bank.sv]
// Function
// - Mode codes 0 stop, 1 run, 2 reference
// - Reference done stores values, mode goes to 1
// - Mode 1 runs detection and raises alarms
// - Period in seconds, 20 to 65535, default 180
// - Period, priority, mask writable only in stop
// - Write classes follow block operating mode; every register except block mode uses WR_AUTO, allowed in all modes
// - Flag bits 2 to 7 report blocking results
// - Bits 8-11 invalid refs, 12-14 range, temperature
// - Mask bit 15 makes outputs uncertain on abnormality
// - Mask bits link flags to alert, default 0x08FC
// - High-side alert from its listed conditions
// - Low-side alert from its listed conditions
// - One alert priority for both, default 1
// - Compensated ratio uses average pressure correction
// - Plain ratio uses fluctuation ratio only
// - Reference ends after 180 s, time recorded
// - Blockage needs consecutive hits, default three
// - Compensation select 0 compensated, 1 plain
`timescale 1ns/1ps
`include "blockage_diag_defs.svh"

module blockage_diag_param_bank #(
   parameter int CYC_PER_SEC = `CLK_FREQ_HZ * `SECOND_TICK_S,
   parameter int REF_SECONDS = `REF_SAMPLE_S
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [13:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [5:0]  det_hit_i,
   input  wire logic [3:0]  ref_invalid_i,
   input  wire logic        out_of_range_i,
   input  wire logic        flange_temp_low_i,
   input  wire logic        flange_temp_high_i,
   input  wire logic [15:0] plain_dp_ratio_i,
   input  wire logic [15:0] dp_avg_ratio_i,
   output logic      [15:0] dp_ratio_o,
   output logic             period_end_o,
   output logic             ref_capture_o,
   output logic             detect_run_o,
   output logic             high_alert_o,
   output logic             low_alert_o,
   output logic      [7:0]  alert_priority_o,
   output logic             linked_alarm_o,
   output logic             output_uncertain_o
);

   // ***************************************************************
   // Helper functions
   // ***************************************************************

   // Byte-lane merge for 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
      logic [15:0] r;
      r = old_v;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction : merge16

   // Write permission by class and block mode
   function automatic logic wr_allowed(input blockage_diag_pkg::wr_class_e cls,
                                       input blockage_diag_pkg::blk_mode_e mode);
      logic ok;
      case (cls)
         blockage_diag_pkg::WR_OOS: begin
            ok = (mode == blockage_diag_pkg::BLK_OOS);
         end
         blockage_diag_pkg::WR_MAN: begin
            ok = (mode != blockage_diag_pkg::BLK_AUTO);
         end
         default: begin
            ok = 1'b1;
         end
      endcase
      return ok;
   endfunction : wr_allowed

   // Mode selector value as software sees it
   function automatic logic [7:0] mode_code(input blockage_diag_pkg::diag_fsm_e s);
      logic [7:0] c;
      case (s)
         blockage_diag_pkg::ST_RUN: begin
            c = 8'h01;
         end
         blockage_diag_pkg::ST_REF: begin
            c = 8'h02;
         end
         default: begin
            c = 8'h00;
         end
      endcase
      return c;
   endfunction : mode_code

   // ***************************************************************
   // State
   // ***************************************************************
   blockage_diag_pkg::bank_state_s q_ff;
   blockage_diag_pkg::bank_state_s nxt_q;

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   always_comb begin
      logic        req;
      logic        tick;
      logic        gate_ok;
      logic [11:0] idx;
      logic [31:0] rdat;
      logic [31:0] prod;
      logic [15:0] cratio;
      logic [15:0] wr16;
      logic [15:0] phase_inc;

      req       = wb_cyc_i & wb_stb_i & ~q_ff.wb_ack;
      tick      = 1'b0;
      gate_ok   = 1'b0;
      idx       = wb_adr_i[13:2];
      rdat      = 32'h0000_0000;
      prod      = 32'h0000_0000;
      cratio    = 16'h0000;
      wr16      = 16'h0000;
      phase_inc = q_ff.phase_cnt + 16'h0001;
      nxt_q     = q_ff;

      nxt_q.wb_ack      = 1'b0;
      nxt_q.period_end  = 1'b0;
      nxt_q.ref_capture = 1'b0;

      // One-second prescaler; long count is a parameter for simulation
      if (q_ff.sec_cnt >= 32'(CYC_PER_SEC - 1)) begin
         nxt_q.sec_cnt = 32'h0000_0000;
         nxt_q.uptime  = q_ff.uptime + 32'h0000_0001;
         tick          = 1'b1;
      end else begin
         nxt_q.sec_cnt = q_ff.sec_cnt + 32'h0000_0001;
      end

      // Diagnosis sequencing
      case (q_ff.fsm)
         blockage_diag_pkg::ST_STOP: begin
            // Stopped: no detection, stale detection and range flags dropped, invalid-reference bits kept
            nxt_q.phase_cnt = 16'h0000;
            nxt_q.hit_cnt   = '0;
            nxt_q.flags[`FLG_DETECT_MSB:`FLG_DETECT_LSB] = 6'h00;
            nxt_q.flags[`FLG_FLANGE_HIGH:`FLG_OUT_OF_RANGE] = 3'h0;
         end

         blockage_diag_pkg::ST_RUN: begin
            // Range and temperature conditions follow the inputs
            nxt_q.flags[`FLG_OUT_OF_RANGE] = out_of_range_i;
            nxt_q.flags[`FLG_FLANGE_LOW]   = flange_temp_low_i;
            nxt_q.flags[`FLG_FLANGE_HIGH]  = flange_temp_high_i;
            if (tick) begin
               if (phase_inc >= q_ff.period) begin
                  // Period boundary: judge each condition
                  nxt_q.phase_cnt  = 16'h0000;
                  nxt_q.period_end = 1'b1;
                  for (int k = 0; k < 6; k++) begin
                     if (det_hit_i[k]) begin
                        if (q_ff.hit_cnt[k] != 8'hff) begin
                           nxt_q.hit_cnt[k] = q_ff.hit_cnt[k] + 8'h01;
                        end
                     end else begin
                        nxt_q.hit_cnt[k] = 8'h00;
                     end
                     // Zero limit treated as one hit
                     nxt_q.flags[`FLG_DETECT_LSB + k] =
                        (nxt_q.hit_cnt[k] >= q_ff.hit_limit) &&
                        (nxt_q.hit_cnt[k] != 8'h00);
                  end
               end else begin
                  nxt_q.phase_cnt = phase_inc;
               end
            end
         end

         blockage_diag_pkg::ST_REF: begin
            // Sampling runs on whole seconds until the fixed span
            if (tick) begin
               if (phase_inc >= 16'(REF_SECONDS)) begin
                  nxt_q.phase_cnt   = 16'h0000;
                  nxt_q.ref_capture = 1'b1;
                  nxt_q.ref_time    = q_ff.uptime;
                  nxt_q.flags[`FLG_INVALID_MSB:`FLG_INVALID_LSB] = ref_invalid_i;
                  nxt_q.fsm         = blockage_diag_pkg::ST_RUN;
               end else begin
                  nxt_q.phase_cnt = phase_inc;
               end
            end
         end

         default: begin
            nxt_q.fsm = blockage_diag_pkg::ST_STOP;
         end
      endcase

      // Differential ratio, compensated product saturates
      prod = plain_dp_ratio_i * dp_avg_ratio_i;
      if (prod[31:24] != 8'h00) begin
         cratio = 16'hffff;
      end else begin
         cratio = prod[23:8];
      end
      nxt_q.dp_ratio = q_ff.comp_sel ? plain_dp_ratio_i : cratio;

      // Read mux, answers zero on unmapped indices
      case (idx)
         `IDX_DIAG_MODE_SELECT:   rdat = {24'h00_0000, mode_code(q_ff.fsm)};
         `IDX_ACQUISITION_PERIOD: rdat = {16'h0000, q_ff.period};
         `IDX_ALERT_PRIORITY:     rdat = {24'h00_0000, q_ff.priority_val};
         `IDX_DIAG_RESULT_FLAGS:  rdat = {16'h0000, q_ff.flags};
         `IDX_HIGH_SIDE_ALERT:    rdat = {16'h0000, q_ff.high_alert};
         `IDX_LOW_SIDE_ALERT:     rdat = {16'h0000, q_ff.low_alert};
         `IDX_ALARM_LINK_MASK:    rdat = {16'h0000, q_ff.mask};
         `IDX_COMP_SELECT:        rdat = {31'h0000_0000, q_ff.comp_sel};
         `IDX_HIT_LIMIT:          rdat = {24'h00_0000, q_ff.hit_limit};
         `IDX_BLOCK_MODE:         rdat = {30'h0000_0000, q_ff.blk_mode};
         `IDX_DIAG_STATUS:        rdat = {29'h0000_0000, q_ff.wr_reject,
                                          q_ff.fsm == blockage_diag_pkg::ST_REF,
                                          q_ff.fsm == blockage_diag_pkg::ST_RUN};
         `IDX_REF_CAPTURE_TIME:   rdat = q_ff.ref_time;
         `IDX_DP_RATIO:           rdat = {16'h0000, q_ff.dp_ratio};
         default:                 rdat = 32'h0000_0000;
      endcase

      // Bus access: one registered ack per request
      if (req) begin
         nxt_q.wb_ack = 1'b1;
         nxt_q.wb_dat = wb_we_i ? 32'h0000_0000 : rdat;
         gate_ok = (q_ff.fsm == blockage_diag_pkg::ST_STOP) &&
                   wr_allowed(blockage_diag_pkg::WR_AUTO, q_ff.blk_mode);

         if (wb_we_i && wb_sel_i[0]) begin
            // Host write wins over the automatic reference hand-off
            case (idx)
               `IDX_DIAG_MODE_SELECT: begin
                  if (!wr_allowed(blockage_diag_pkg::WR_AUTO, q_ff.blk_mode) ||
                      wb_dat_i[7:0] > 8'h02) begin
                     nxt_q.wr_reject = 1'b1;
                  end else begin
                     nxt_q.wr_reject = 1'b0;
                     nxt_q.phase_cnt = 16'h0000;
                     case (wb_dat_i[1:0])
                        2'b01:   nxt_q.fsm = blockage_diag_pkg::ST_RUN;
                        2'b10:   nxt_q.fsm = blockage_diag_pkg::ST_REF;
                        default: nxt_q.fsm = blockage_diag_pkg::ST_STOP;
                     endcase
                  end
               end

               `IDX_ACQUISITION_PERIOD: begin
                  wr16 = merge16(q_ff.period, wb_dat_i, wb_sel_i);
                  if (gate_ok && wr16 >= `PERIOD_MIN) begin
                     nxt_q.period    = wr16;
                     nxt_q.wr_reject = 1'b0;
                  end else begin
                     nxt_q.wr_reject = 1'b1;
                  end
               end

               `IDX_ALERT_PRIORITY: begin
                  if (gate_ok) begin
                     nxt_q.priority_val = wb_dat_i[7:0];
                     nxt_q.wr_reject    = 1'b0;
                  end else begin
                     nxt_q.wr_reject = 1'b1;
                  end
               end

               `IDX_ALARM_LINK_MASK: begin
                  if (gate_ok) begin
                     nxt_q.mask      = merge16(q_ff.mask, wb_dat_i, wb_sel_i);
                     nxt_q.wr_reject = 1'b0;
                  end else begin
                     nxt_q.wr_reject = 1'b1;
                  end
               end

               `IDX_COMP_SELECT: begin
                  if (wr_allowed(blockage_diag_pkg::WR_AUTO, q_ff.blk_mode)) begin
                     nxt_q.comp_sel  = wb_dat_i[0];
                     nxt_q.wr_reject = 1'b0;
                  end
               end

               `IDX_HIT_LIMIT: begin
                  if (gate_ok) begin
                     nxt_q.hit_limit = wb_dat_i[7:0];
                     nxt_q.wr_reject = 1'b0;
                  end else begin
                     nxt_q.wr_reject = 1'b1;
                  end
               end

               `IDX_BLOCK_MODE: begin
                  if (wb_dat_i[1:0] != 2'b11) begin
                     nxt_q.blk_mode  = blockage_diag_pkg::blk_mode_e'(wb_dat_i[1:0]);
                     nxt_q.wr_reject = 1'b0;
                  end else begin
                     nxt_q.wr_reject = 1'b1;
                  end
               end

               default: begin
                  // Result and summary words are not host writable
                  nxt_q.wr_reject = q_ff.wr_reject;
               end
            endcase
         end
      end

      // Summaries and links derived from the new flag word
      nxt_q.high_alert = nxt_q.flags & `HIGH_SIDE_SOURCES;
      nxt_q.low_alert  = nxt_q.flags & `LOW_SIDE_SOURCES;
      nxt_q.linked     = |(nxt_q.flags[14:0] & nxt_q.mask[14:0]);
      nxt_q.run_flag   = (nxt_q.fsm == blockage_diag_pkg::ST_RUN);
      nxt_q.high_any   = |nxt_q.high_alert;
      nxt_q.low_any    = |nxt_q.low_alert;
      nxt_q.uncertain  = nxt_q.mask[`MASK_UNCERTAIN_LINK] &
                         (|nxt_q.flags[14:0]);
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   // Synchronous reset to factory defaults
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff              <= '0;
         q_ff.fsm          <= blockage_diag_pkg::ST_STOP;
         q_ff.blk_mode     <= blockage_diag_pkg::BLK_AUTO;
         q_ff.period       <= `RST_ACQUISITION_PERIOD;
         q_ff.priority_val <= `RST_ALERT_PRIORITY;
         q_ff.mask         <= `RST_ALARM_LINK_MASK;
         q_ff.hit_limit    <= `RST_HIT_LIMIT;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // ***************************************************************
   // Outputs, all straight from the state register
   // ***************************************************************
   assign wb_dat_o           = q_ff.wb_dat;
   assign wb_ack_o           = q_ff.wb_ack;
   assign dp_ratio_o         = q_ff.dp_ratio;
   assign period_end_o       = q_ff.period_end;
   assign ref_capture_o      = q_ff.ref_capture;
   assign detect_run_o       = q_ff.run_flag;
   assign high_alert_o       = q_ff.high_any;
   assign low_alert_o        = q_ff.low_any;
   assign alert_priority_o   = q_ff.priority_val;
   assign linked_alarm_o     = q_ff.linked;
   assign output_uncertain_o = q_ff.uncertain;

endmodule : blockage_diag_param_bank

// [blockage_diag_param_bank_monitor.sv]
`timescale 1ns/1ps

// ***************************************************************
// Port-level checks on bus handshake and diagnosis outputs
// ***************************************************************
module blockage_diag_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        period_end_o,
   input wire logic        ref_capture_o,
   input wire logic        detect_run_o,
   input wire logic        high_alert_o,
   input wire logic        low_alert_o,
   input wire logic [7:0]  alert_priority_o
);
   logic [1:0] evt_ff;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // History of judging events, alerts may trail them
   always_ff @(posedge clk_i) begin
      if (rst_i) evt_ff <= 2'b00;
      else       evt_ff <= {evt_ff[0], period_end_o | ref_capture_o};
   end

   sequence req_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence write_taken;
      req_taken ##0 wb_we_i;
   endsequence

   a_ack_follows_req: assert property (req_taken |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_stb_i) && $past(wb_cyc_i))
      else $error("ack without request");
   a_write_reads_zero: assert property (write_taken |=> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero on write");
   a_upper_bits_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_period_spacing: assert property (period_end_o |=> !period_end_o [*8])
      else $error("period pulses too close");
   a_capture_to_run: assert property (ref_capture_o |-> ##[0:2] detect_run_o)
      else $error("no run after reference end");
   a_priority_on_write: assert property ($changed(alert_priority_o) |->
      (wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)))
      else $error("priority changed without write");
   a_alert_has_cause: assert property ($rose(high_alert_o || low_alert_o) |->
      (period_end_o || ref_capture_o || (|evt_ff)))
      else $error("alert rose without judging event");
endmodule : blockage_diag_checker

// [blockage_diag_pkg.sv]
package blockage_diag_pkg;

   // ***************************************************************
   // Types
   // ***************************************************************
   // Gray along stop -> run -> reference
   typedef enum logic [1:0] {
      ST_STOP = 2'b00,
      ST_RUN  = 2'b01,
      ST_REF  = 2'b11
   } diag_fsm_e;

   typedef enum logic [1:0] {
      BLK_OOS  = 2'b00,
      BLK_MAN  = 2'b01,
      BLK_AUTO = 2'b10
   } blk_mode_e;

   typedef enum logic [1:0] {
      WR_OOS  = 2'b00,
      WR_MAN  = 2'b01,
      WR_AUTO = 2'b10
   } wr_class_e;

   typedef struct packed {
      logic            wb_ack;
      logic [31:0]     wb_dat;
      diag_fsm_e       fsm;
      blk_mode_e       blk_mode;
      logic [15:0]     period;
      logic [7:0]      priority_val;
      logic [15:0]     flags;
      logic [15:0]     mask;
      logic            comp_sel;
      logic [7:0]      hit_limit;
      logic [31:0]     sec_cnt;
      logic [31:0]     uptime;
      logic [15:0]     phase_cnt;
      logic [5:0][7:0] hit_cnt;
      logic [31:0]     ref_time;
      logic            wr_reject;
      logic [15:0]     dp_ratio;
      logic [15:0]     high_alert;
      logic [15:0]     low_alert;
      logic            linked;
      logic            uncertain;
      logic            period_end;
      logic            ref_capture;
      logic            run_flag;
      logic            high_any;
      logic            low_any;
   } bank_state_s;

endpackage : blockage_diag_pkg

// [diag_front_model.sv]
`timescale 1ns/1ps

// ***************************************************************
// Sensing front end: blocked valves show as threshold crossings
// ***************************************************************
module diag_front_model (
   input  wire logic        blk_hi_i,
   input  wire logic        blk_lo_i,
   output logic      [5:0]  det_hit_o,
   output logic      [3:0]  ref_invalid_o,
   output logic             out_of_range_o,
   output logic             temp_low_o,
   output logic             temp_high_o,
   output logic      [15:0] plain_ratio_o,
   output logic      [15:0] avg_ratio_o
);
   // Steady process, so statistics are constants
   assign det_hit_o      = {1'b0, blk_hi_i, blk_lo_i, 3'b000};
   assign ref_invalid_o  = 4'h0;
   assign out_of_range_o = 1'b0;
   assign temp_low_o     = 1'b0;
   assign temp_high_o    = 1'b0;
   assign plain_ratio_o  = 16'h0200;
   assign avg_ratio_o    = 16'h0180;
endmodule : diag_front_model

// [tb_blockage_diag_param_bank.sv]
`timescale 1ns/1ps
`include "blockage_diag_defs.svh"

module tb_blockage_diag_param_bank;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [13:0] wb_adr_i = 14'h0000;
   logic [3:0]  wb_sel_i = 4'h0, ref_invalid_i;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic        blk_hi = 1'b0, blk_lo = 1'b0, wb_ack_o, period_end_o, ref_capture_o;
   logic [5:0]  det_hit_i;
   logic [15:0] plain_dp_ratio_i, dp_avg_ratio_i, dp_ratio_o;
   logic        out_of_range_i, flange_temp_low_i, flange_temp_high_i, detect_run_o;
   logic        high_alert_o, low_alert_o, linked_alarm_o, output_uncertain_o;
   logic [7:0]  alert_priority_o;
   logic [31:0] rst_tab [7] = '{32'h0000_0000, 32'h0000_00b4, 32'h0000_0001,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_08fc};
   int          err_count = 0, tests_run = 0;

   always #12.5 clk_i = ~clk_i;

   blockage_diag_param_bank #(.CYC_PER_SEC(10), .REF_SECONDS(3)) blockage_diag_param_bank_inst (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .det_hit_i, .ref_invalid_i, .out_of_range_i, .flange_temp_low_i,
      .flange_temp_high_i, .plain_dp_ratio_i, .dp_avg_ratio_i, .dp_ratio_o, .period_end_o,
      .ref_capture_o, .detect_run_o, .high_alert_o, .low_alert_o, .alert_priority_o,
      .linked_alarm_o, .output_uncertain_o);

   diag_front_model diag_front_model_inst (.blk_hi_i(blk_hi), .blk_lo_i(blk_lo),
      .det_hit_o(det_hit_i), .ref_invalid_o(ref_invalid_i), .out_of_range_o(out_of_range_i),
      .temp_low_o(flange_temp_low_i), .temp_high_o(flange_temp_high_i),
      .plain_ratio_o(plain_dp_ratio_i), .avg_ratio_o(dp_avg_ratio_i));

   // ***************************************************************
   // Bus cycles and comparisons
   // ***************************************************************
   task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      // Waits for ack with no local bound; only the watchdog may cut it short
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      chk(nm, {31'h0000_0000, exp}, {31'h0000_0000, got});
   endtask : chk_bit

   task automatic rdchk(input string nm, input logic [11:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0000_0000);
      chk(nm, exp, rd);
   endtask : rdchk

   // Bounded pulse waits
   task automatic wait_evt(input logic cap);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while ((cap ? ref_capture_o : period_end_o) !== 1'b1 && n < 1000);
      chk_bit("event pulse", 1'b1, n < 1000);
   endtask : wait_evt

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rst_tab[i]) rdchk("reset value", 12'h812 + 12'(i), rst_tab[i]);
      chk("priority pin", 32'h0000_0001, 32'(alert_priority_o));
      $display("test reset values done");
      bus(1'b1, `IDX_BLOCK_MODE, 32'h0000_0000);
      rdchk("block mode", `IDX_BLOCK_MODE, 32'h0000_0000);
      bus(1'b1, `IDX_ACQUISITION_PERIOD, 32'h0000_0013);
      rdchk("short period", `IDX_ACQUISITION_PERIOD, 32'h0000_00b4);
      rdchk("reject status", `IDX_DIAG_STATUS, 32'h0000_0004);
      bus(1'b1, `IDX_ACQUISITION_PERIOD, 32'h0000_0014);
      rdchk("min period", `IDX_ACQUISITION_PERIOD, 32'h0000_0014);
      bus(1'b1, `IDX_ALERT_PRIORITY, 32'h0000_0005);
      rdchk("priority", `IDX_ALERT_PRIORITY, 32'h0000_0005);
      chk("priority pin", 32'h0000_0005, 32'(alert_priority_o));
      bus(1'b1, `IDX_DIAG_RESULT_FLAGS, 32'h0000_ffff);
      rdchk("flags read only", `IDX_DIAG_RESULT_FLAGS, 32'h0000_0000);
      bus(1'b1, `IDX_DIAG_MODE_SELECT, 32'h0000_0003);
      rdchk("bad mode code", `IDX_DIAG_MODE_SELECT, 32'h0000_0000);
      bus(1'b1, 12'h900, 32'h0000_1234);
      rdchk("unmapped", 12'h900, 32'h0000_0000);
      $display("test stop mode writes done");
      // High side valve shut, then a fresh reference
      blk_hi <= 1'b1;
      bus(1'b1, `IDX_DIAG_MODE_SELECT, 32'h0000_0002);
      rdchk("reference mode", `IDX_DIAG_MODE_SELECT, 32'h0000_0002);
      wait_evt(1'b1);
      rdchk("auto run mode", `IDX_DIAG_MODE_SELECT, 32'h0000_0001);
      chk_bit("run pin", 1'b1, detect_run_o);
      bus(1'b1, `IDX_ACQUISITION_PERIOD, 32'h0000_0030);
      rdchk("gated period", `IDX_ACQUISITION_PERIOD, 32'h0000_0014);
      bus(1'b1, `IDX_ALARM_LINK_MASK, 32'h0000_0000);
      rdchk("gated mask", `IDX_ALARM_LINK_MASK, 32'h0000_08fc);
      $display("test reference done");
      for (int k = 1; k <= 3; k++) begin
         wait_evt(1'b0);
         rdchk("flags", `IDX_DIAG_RESULT_FLAGS,
               (k == 3) ? 32'h0000_0040 : 32'h0000_0000);
      end
      chk_bit("high alert", 1'b1, high_alert_o);
      chk_bit("low alert", 1'b0, low_alert_o);
      chk_bit("linked alarm", 1'b1, linked_alarm_o);
      chk_bit("uncertain", 1'b0, output_uncertain_o);
      rdchk("high summary", `IDX_HIGH_SIDE_ALERT, 32'h0000_0040);
      rdchk("low summary", `IDX_LOW_SIDE_ALERT, 32'h0000_0000);
      $display("test detection done");
      bus(1'b1, `IDX_DIAG_MODE_SELECT, 32'h0000_0000);
      bus(1'b1, `IDX_ALARM_LINK_MASK, 32'h0000_8000);
      rdchk("mask", `IDX_ALARM_LINK_MASK, 32'h0000_8000);
      bus(1'b1, `IDX_DIAG_MODE_SELECT, 32'h0000_0001);
      repeat (3) wait_evt(1'b0);
      repeat (3) @(posedge clk_i);
      chk_bit("uncertain", 1'b1, output_uncertain_o);
      chk_bit("unlinked alarm", 1'b0, linked_alarm_o);
      $display("test status link done");
      chk("compensated ratio", 32'h0000_0300, 32'(dp_ratio_o));
      bus(1'b1, `IDX_COMP_SELECT, 32'h0000_0001);
      repeat (3) @(posedge clk_i);
      chk("plain ratio", 32'h0000_0200, 32'(dp_ratio_o));
      $display("test ratio select done");
      final_report();
   end

   // Whole run is near 1330 cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      final_report();
   end
endmodule : tb_blockage_diag_param_bank

bind blockage_diag_param_bank blockage_diag_checker blockage_diag_checker_inst (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .period_end_o,
   .ref_capture_o, .detect_run_o, .high_alert_o, .low_alert_o, .alert_priority_o);
